// *** rtl/urx_regs.svh ***
`ifndef URX_REGS_SVH
`define URX_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define URX_ADDR_W          2
`define URX_OFS_STATUS_ONE  2'h0
`define URX_OFS_STATUS_TWO  2'h1
`define URX_OFS_DATA        2'h2
`define URX_OFS_BIT_RATE    2'h3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define URX_S1_FULL         5
`define URX_S1_IDLE         4
`define URX_S1_OVERRUN      3
`define URX_S1_NOISE        2
`define URX_S1_FRAMING      1
`define URX_S1_PARITY       0
`define URX_S2_BREAK        1
`define URX_S2_PROGRESS     0
`define URX_BR_PRE_HI       5
`define URX_BR_PRE_LO       4
`define URX_BR_RATE_HI      2
`define URX_BR_RATE_LO      0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define URX_RST_BYTE        8'h00
`define URX_RST_PRE         2'h0
`define URX_RST_RATE        3'h0
`define URX_IDLE_BITS_8     4'hA
`define URX_IDLE_BITS_9     4'hB
`define URX_PD_CODE0        4'h1
`define URX_PD_CODE1        4'h3
`define URX_PD_CODE2        4'h4
`define URX_PD_CODE3        4'hD
`define URX_SAMPLE_DIV      2'h3
`define URX_SAMPLES_BIT     4'hF
`endif

// *** rtl/urx_pkg.sv ***
package urx_pkg;
    typedef logic [7:0] urx_byte_t;
    typedef logic [1:0] urx_pre_t;
    typedef logic [2:0] urx_rate_t;
    typedef logic [3:0] urx_cnt_t;
endpackage

// *** rtl/urx_top.sv ***
`include "urx_regs.svh"

module urx_top
(
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic [`URX_ADDR_W-1:0]     bus_addr,
    input  wire logic [7:0]                 bus_wdata,
    input  wire logic                       bus_wr,
    input  wire logic                       bus_rd,
    output logic [7:0]                      bus_rdata,
    input  wire logic                       receive_pin,
    input  wire logic                       buffered_crystal_clock,
    input  wire logic                       serial_clock_source_select,
    input  wire logic                       receiver_enable,
    input  wire logic                       nine_bit_mode,
    input  wire logic                       idle_line_irq_enable,
    input  wire logic                       overrun_irq_enable,
    input  wire logic                       noise_irq_enable,
    input  wire logic                       framing_irq_enable,
    input  wire logic                       parity_irq_enable,
    input  wire logic                       char_done,
    input  wire logic [7:0]                 char_data,
    input  wire logic                       char_bit8,
    input  wire logic                       noise_det,
    input  wire logic                       stop_low_det,
    input  wire logic                       parity_det,
    input  wire logic                       break_det,
    input  wire logic                       first_slot_low,
    input  wire logic                       false_start,
    output logic                            sample_tick,
    output logic                            bit_tick,
    output logic                            receiver_full_flag,
    output logic                            received_ninth_bit,
    output logic                            rx_irq,
    output logic                            err_irq,
    output logic [7:0]                      tx_byte,
    output logic                            tx_load
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic rx_meta_reg;
    logic rx_sync_reg;
    logic xc_meta_reg;
    logic xc_sync_reg;
    logic xc_prev_reg;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            xc_meta_reg <= 1'b0;
            xc_sync_reg <= 1'b0;
            xc_prev_reg <= 1'b0;
        end
        else
        begin
            rx_meta_reg <= receive_pin;
            rx_sync_reg <= rx_meta_reg;
            xc_meta_reg <= buffered_crystal_clock;
            xc_sync_reg <= xc_meta_reg;
            xc_prev_reg <= xc_sync_reg;
        end
    end

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    logic rd_s1;
    logic rd_s2;
    logic rd_data;
    logic wr_data;
    logic wr_rate;

    assign rd_s1   = bus_rd && (bus_addr == `URX_OFS_STATUS_ONE);
    assign rd_s2   = bus_rd && (bus_addr == `URX_OFS_STATUS_TWO);
    assign rd_data = bus_rd && (bus_addr == `URX_OFS_DATA);
    assign wr_data = bus_wr && (bus_addr == `URX_OFS_DATA);
    assign wr_rate = bus_wr && (bus_addr == `URX_OFS_BIT_RATE);

    // ----------------------------------------------------------------
    // Bit rate generator
    // ----------------------------------------------------------------
    function automatic urx_pkg::urx_cnt_t prescale_divisor(input urx_pkg::urx_pre_t code);
        urx_pkg::urx_cnt_t d;
        d = `URX_PD_CODE0;
        unique case (code)
            2'h0: d = `URX_PD_CODE0;
            2'h1: d = `URX_PD_CODE1;
            2'h2: d = `URX_PD_CODE2;
            2'h3: d = `URX_PD_CODE3;
        endcase
        return d;
    endfunction

    urx_pkg::urx_pre_t  prescaler_field_reg;
    urx_pkg::urx_rate_t rate_divisor_field_reg;
    urx_pkg::urx_cnt_t  pre_cnt_reg;
    logic [6:0]         rate_cnt_reg;
    logic [1:0]         quad_cnt_reg;
    urx_pkg::urx_cnt_t  samp_cnt_reg;
    logic               src_en;
    logic               pre_tick;
    logic               rate_tick;
    logic [6:0]         rate_mask;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prescaler_field_reg    <= `URX_RST_PRE;
            rate_divisor_field_reg <= `URX_RST_RATE;
        end
        else if (wr_rate)
        begin
            prescaler_field_reg    <= bus_wdata[`URX_BR_PRE_HI:`URX_BR_PRE_LO];
            rate_divisor_field_reg <= bus_wdata[`URX_BR_RATE_HI:`URX_BR_RATE_LO];
        end
    end

    // Crystal clock is sampled, so it must stay well below half the bus rate
    assign src_en    = serial_clock_source_select ? (xc_sync_reg && !xc_prev_reg)
                                                  : 1'b1;
    assign pre_tick  = src_en &&
                       (pre_cnt_reg == prescale_divisor(prescaler_field_reg) - 4'h1);
    // Rate divisor is 2**code: tick when the low code bits of a free counter wrap
    assign rate_mask = 7'((8'h01 << rate_divisor_field_reg) - 8'h01);
    assign rate_tick = pre_tick && ((rate_cnt_reg & rate_mask) == rate_mask);
    // 64 = 4 dividing to sample rate times 16 samples a bit
    assign sample_tick = rate_tick && (quad_cnt_reg == `URX_SAMPLE_DIV);
    assign bit_tick    = sample_tick && (samp_cnt_reg == `URX_SAMPLES_BIT);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pre_cnt_reg  <= 4'h0;
            rate_cnt_reg <= 7'h00;
            quad_cnt_reg <= 2'h0;
            samp_cnt_reg <= 4'h0;
        end
        else
        begin
            if (pre_tick)
                pre_cnt_reg <= 4'h0;
            else if (src_en)
                pre_cnt_reg <= pre_cnt_reg + 4'h1;
            if (pre_tick)
                rate_cnt_reg <= rate_cnt_reg + 7'h01;
            if (rate_tick)
                quad_cnt_reg <= quad_cnt_reg + 2'h1;
            if (sample_tick)
                samp_cnt_reg <= samp_cnt_reg + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Data buffer, no reset on contents
    // ----------------------------------------------------------------
    urx_pkg::urx_byte_t rx_buf_reg;
    logic               ninth_reg;
    logic               accept;

    assign accept = (char_done || break_det) && !receiver_full_flag;

    always_ff @(posedge clk)
    begin
        if (accept)
        begin
            rx_buf_reg <= break_det ? `URX_RST_BYTE : char_data;
            ninth_reg  <= nine_bit_mode ? (char_bit8 && !break_det)
                                        : (break_det ? 1'b0 : char_data[7]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (wr_data)
            tx_byte <= bus_wdata;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            tx_load <= 1'b0;
        else
            tx_load <= wr_data;
    end

    assign received_ninth_bit = ninth_reg;

    // ----------------------------------------------------------------
    // Clearing sequence: status read arms, data read clears
    // ----------------------------------------------------------------
    logic [5:0] s1_flags;
    logic [5:0] s1_arm_reg;
    logic       brk_arm_reg;
    logic [5:0] s1_clr;
    logic       brk_clr;

    logic full_reg;
    logic idle_reg;
    logic over_reg;
    logic noise_reg;
    logic frame_reg;
    logic par_reg;
    logic brk_reg;
    logic prog_reg;

    assign s1_flags = {full_reg, idle_reg, over_reg, noise_reg, frame_reg, par_reg};

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_arm_reg  <= 6'h00;
            brk_arm_reg <= 1'b0;
        end
        else if (rd_data)
        begin
            s1_arm_reg  <= 6'h00;
            brk_arm_reg <= 1'b0;
        end
        else
        begin
            if (rd_s1)
            begin
                // Only flags already up are armed; noise arms on any read
                s1_arm_reg <= s1_flags | (6'h01 << `URX_S1_NOISE);
            end
            if (rd_s2)
                brk_arm_reg <= brk_reg;
        end
    end

    assign s1_clr  = rd_data ? s1_arm_reg : 6'h00;
    assign brk_clr = rd_data && brk_arm_reg;

    // ----------------------------------------------------------------
    // Receive flags; a set in the clearing cycle wins
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            full_reg  <= 1'b0;
            over_reg  <= 1'b0;
            noise_reg <= 1'b0;
            frame_reg <= 1'b0;
            par_reg   <= 1'b0;
        end
        else
        begin
            full_reg  <= accept || (full_reg && !s1_clr[`URX_S1_FULL]);
            over_reg  <= ((char_done || break_det) && full_reg) ||
                         (over_reg && !s1_clr[`URX_S1_OVERRUN]);
            noise_reg <= noise_det || (noise_reg && !s1_clr[`URX_S1_NOISE]);
            frame_reg <= stop_low_det || break_det ||
                         (frame_reg && !s1_clr[`URX_S1_FRAMING]);
            par_reg   <= parity_det || (par_reg && !s1_clr[`URX_S1_PARITY]);
        end
    end

    assign receiver_full_flag = full_reg;

    // ----------------------------------------------------------------
    // Break flag with line-high rearm
    // ----------------------------------------------------------------
    logic brk_ok_reg;
    logic brk_set;

    assign brk_set = break_det && brk_ok_reg;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            brk_reg    <= 1'b0;
            brk_ok_reg <= 1'b1;
        end
        else
        begin
            brk_reg <= brk_set || (brk_reg && !brk_clr);
            if (brk_set)
                brk_ok_reg <= 1'b0;
            else if (rx_sync_reg && !brk_reg)
                brk_ok_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Idle detection
    // ----------------------------------------------------------------
    urx_pkg::urx_cnt_t idle_cnt_reg;
    urx_pkg::urx_cnt_t idle_need;
    logic              idle_ok_reg;
    logic              re_prev_reg;
    logic              idle_hit;

    assign idle_need = nine_bit_mode ? `URX_IDLE_BITS_9 : `URX_IDLE_BITS_8;
    assign idle_hit  = bit_tick && rx_sync_reg && (idle_cnt_reg == idle_need - 4'h1);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            idle_cnt_reg <= 4'h0;
        else if (!rx_sync_reg || !receiver_enable)
            idle_cnt_reg <= 4'h0;
        else if (bit_tick && (idle_cnt_reg != idle_need))
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idle_reg    <= 1'b0;
            idle_ok_reg <= 1'b0;
            re_prev_reg <= 1'b0;
        end
        else
        begin
            re_prev_reg <= receiver_enable;
            idle_reg    <= (idle_hit && idle_ok_reg) ||
                           (idle_reg && !s1_clr[`URX_S1_IDLE]);
            if (accept && char_done)
                idle_ok_reg <= 1'b1;
            else if ((receiver_enable && !re_prev_reg) || s1_clr[`URX_S1_IDLE] ||
                     (idle_hit && idle_ok_reg))
                idle_ok_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Reception in progress
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            prog_reg <= 1'b0;
        else if (first_slot_low)
            prog_reg <= 1'b1;
        else if (false_start || idle_hit)
            prog_reg <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Requests and read data
    // ----------------------------------------------------------------
    assign rx_irq  = idle_reg && idle_line_irq_enable;
    assign err_irq = (over_reg && overrun_irq_enable) ||
                     (noise_reg && noise_irq_enable) ||
                     (frame_reg && framing_irq_enable) ||
                     (par_reg && parity_irq_enable);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            bus_rdata <= `URX_RST_BYTE;
        else if (bus_rd)
        begin
            unique case (bus_addr)
                `URX_OFS_STATUS_ONE: bus_rdata <= {2'b00, s1_flags};
                `URX_OFS_STATUS_TWO: bus_rdata <= {6'h00, brk_reg, prog_reg};
                `URX_OFS_DATA:       bus_rdata <= rx_buf_reg;
                `URX_OFS_BIT_RATE:   bus_rdata <= {2'b00, prescaler_field_reg, 1'b0,
                                                   rate_divisor_field_reg};
            endcase
        end
        else
            bus_rdata <= `URX_RST_BYTE;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    overrun_keep_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (char_done && full_reg) |=> over_reg && $stable(rx_buf_reg))
        else $error("overrun did not hold the buffer");

    overrun_skip_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_s1 && !over_reg) ##1 (!rd_data && !rd_s1)[*3] ##1 (rd_data && over_reg)
        |=> over_reg)
        else $error("overrun cleared without being armed");

    full_clear_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_s1 && full_reg) ##1 !bus_rd ##1 (rd_data && !char_done && !break_det)
        |=> !full_reg)
        else $error("receiver full not cleared");

    idle_set_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(idle_reg) |-> $past(rx_sync_reg) && $past(idle_ok_reg))
        else $error("idle set without high line or arming");

    break_flags_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        brk_set |=> brk_reg && frame_reg && full_reg)
        else $error("break did not set companion flags");

    // Line has stayed low since the break flag was last cleared
    logic brk_low_reg;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            brk_low_reg <= 1'b0;
        else if (brk_clr)
            brk_low_reg <= 1'b1;
        else if (rx_sync_reg)
            brk_low_reg <= 1'b0;
    end

    break_quiet_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        brk_low_reg && !rx_sync_reg && break_det |=> !$rose(brk_reg))
        else $error("break set again without line high");

    error_req_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (over_reg && overrun_irq_enable) |-> err_irq)
        else $error("overrun request missing");

    idle_req_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(idle_reg) && idle_line_irq_enable |-> rx_irq)
        else $error("idle request missing");

    progress_set_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        first_slot_low |=> prog_reg)
        else $error("progress flag did not set");

    rate_div_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rate_divisor_field_reg == 3'h0) && pre_tick |-> rate_tick)
        else $error("rate divisor one not honoured");

endmodule

// *** testbench/urx_line_model.sv ***
module urx_line_model
(
    input  wire logic       clk,
    input  wire logic       bit_tick,
    input  wire logic       brk,
    input  wire logic       go,
    input  wire logic [7:0] byte_in,
    output logic            rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] sh_reg;
    logic [3:0] n_reg = 4'h0;
    // ------------------------------------------------------------
    // Frame: start low, data LSB first, stop high, paced by bit_tick
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (go)
        begin
            sh_reg <= {1'b1, byte_in, 1'b0};
            n_reg  <= 4'hA;
        end
        else if (bit_tick && n_reg != 4'h0)
        begin
            sh_reg <= {1'b1, sh_reg[9:1]};
            n_reg  <= n_reg - 4'h1;
        end
    end
    // Break holds the line low; otherwise the line idles high
    assign rxd = brk ? 1'b0 : ((n_reg == 4'h0) ? 1'b1 : sh_reg[0]);
endmodule

// *** testbench/tb_uart_rx_status_data_baud.sv ***
module tb_uart_rx_status_data_baud;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 0, sys_rst = 1, bus_wr = 0, bus_rd = 0, xclk = 0, nine = 0, re = 1, src = 0;
    logic       brk = 0, go = 0, rxd, c8 = 0, st, bt, full, r8, rx_irq, err_irq, tx_load;
    logic [1:0] bus_addr = 0;
    logic [7:0] bus_wdata = 0, bus_rdata, cdata = 0, tx_byte, rv, b1;
    logic [4:0] en = 0;
    logic [6:0] evt = 0;
    int         n_errors = 0, samples_checked = 0, k;
    always #5 clk = ~clk;
    always #40 xclk = ~xclk;
    urx_top dut_u (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .receive_pin(rxd),
        .buffered_crystal_clock(xclk), .serial_clock_source_select(src),
        .receiver_enable(re), .nine_bit_mode(nine), .idle_line_irq_enable(en[4]),
        .overrun_irq_enable(en[3]), .noise_irq_enable(en[2]), .framing_irq_enable(en[1]),
        .parity_irq_enable(en[0]), .char_done(evt[6]), .char_data(cdata), .char_bit8(c8),
        .noise_det(evt[0]), .stop_low_det(evt[1]), .parity_det(evt[2]), .break_det(evt[3]),
        .first_slot_low(evt[4]), .false_start(evt[5]), .sample_tick(st), .bit_tick(bt),
        .receiver_full_flag(full), .received_ninth_bit(r8), .rx_irq(rx_irq),
        .err_irq(err_irq), .tx_byte(tx_byte), .tx_load(tx_load));
    urx_line_model u_line (.clk(clk), .bit_tick(bt), .brk(brk), .go(go), .byte_in(b1),
        .rxd(rxd));
    // ------------------------------------------------------------
    // Bus and event tasks
    // ------------------------------------------------------------
    task give_verdict;
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task rd(input logic [1:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 chk(nm, e, bus_rdata);
    endtask
    // Pulses one engine event; index 6 is a completed character carrying d
    task ev(input int i, input logic [7:0] d);
        @(posedge clk);
        cdata <= d;
        c8    <= ~d[7];
        evt   <= 7'h01 << i;
        @(posedge clk);
        evt <= 7'h00;
        #1;
    endtask
    function automatic int pd(input int c);
        return (c == 0) ? 1 : (c == 1) ? 3 : (c == 2) ? 4 : 13;
    endfunction
    // Any window of 4 periods holds exactly 4 ticks once the divider settled
    task per(input logic [7:0] code, input int p);
        int c;
        wr(2'h3, code);
        rd(2'h3, code, "bit rate");
        for (c = 0; c < 14000 && !(st && c > p); c++)
            @(posedge clk) #1;
        if (c == 14000)
        begin
            n_errors++;
            give_verdict;
        end
        c = 0;
        repeat (4 * p) @(posedge clk) #1 c += st;
        chk("ticks", 8'h04, c[7:0]);
    endtask
    task wait_irq;
        for (k = 0; k < 3000 && rx_irq !== 1'b1; k++)
            @(posedge clk) #1;
        if (k == 3000)
        begin
            n_errors++;
            give_verdict;
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        k = $urandom(32'hca8ebaa9);
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(2'h0, 8'h00, "status one");
        rd(2'h1, 8'h00, "status two");
        rd(2'h3, 8'h00, "bit rate");
        for (int i = 0; i < 4; i++)
            per({2'h0, i[1:0], 4'h0}, 4 * pd(i));
        for (int i = 1; i < 8; i++)
            per({5'h0, i[2:0]}, 4 << i);
        src <= 1'b1;
        per(8'h00, 32);
        src <= 1'b0;
        wr(2'h3, 8'h00);
        b1 = $urandom;
        nine <= 1'b1;
        ev(6, b1);
        chk("full pin", 8'h01, {7'h0, full});
        rd(2'h0, 8'h20, "full");
        chk("ninth bit", {7'h0, ~b1[7]}, {7'h0, r8});
        ev(6, ~b1);
        rd(2'h0, 8'h28, "overrun");
        chk("err irq off", 8'h00, {7'h0, err_irq});
        en <= 5'h08;
        @(posedge clk) #1 chk("err irq", 8'h01, {7'h0, err_irq});
        en <= 5'h00;
        rd(2'h2, b1, "data");
        rd(2'h0, 8'h00, "cleared");
        ev(6, b1);
        rd(2'h0, 8'h20, "full");
        ev(6, b1);
        rd(2'h2, b1, "data");
        rd(2'h0, 8'h08, "overrun kept");
        rd(2'h2, b1, "data");
        rd(2'h0, 8'h00, "cleared");
        for (int i = 0; i < 3; i++)
        begin
            ev(i, 8'h00);
            rd(2'h0, 8'h04 >> i, "error flag");
            en <= 5'h04 >> i;
            @(posedge clk) #1 chk("err irq", 8'h01, {7'h0, err_irq});
            en <= 5'h00;
            rd(2'h2, b1, "data");
            rd(2'h0, 8'h00, "cleared");
        end
        brk <= 1'b1;
        ev(3, 8'h00);
        rd(2'h1, 8'h02, "break");
        rd(2'h0, 8'h22, "break status");
        chk("ninth bit", 8'h00, {7'h0, r8});
        chk("irqs", 8'h00, {6'h0, rx_irq, err_irq});
        rd(2'h2, 8'h00, "data");
        rd(2'h1, 8'h00, "break clear");
        ev(3, 8'h00);
        rd(2'h1, 8'h00, "no rearm");
        rd(2'h0, 8'h22, "break status");
        rd(2'h2, 8'h00, "data");
        brk <= 1'b0;
        repeat (10) @(posedge clk);
        ev(3, 8'h00);
        rd(2'h1, 8'h02, "rearmed");
        rd(2'h0, 8'h22, "break status");
        rd(2'h2, 8'h00, "data");
        rd(2'h1, 8'h00, "break clear");
        nine <= 1'b0;
        ev(4, 8'h00);
        rd(2'h1, 8'h01, "progress");
        ev(5, 8'h00);
        rd(2'h1, 8'h00, "false start");
        en <= 5'h10;
        b1 = $urandom;
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        ev(6, b1);
        chk("ninth bit", {7'h0, b1[7]}, {7'h0, r8});
        wait_irq;
        rd(2'h0, 8'h30, "idle");
        rd(2'h2, b1, "data");
        rd(2'h0, 8'h00, "cleared");
        // Frame after the clear and after an enable edge: neither arms idle
        for (int j = 0; j < 2; j++)
        begin
            if (j == 1)
            begin
                ev(6, b1);
                re <= 1'b0;
                @(posedge clk) re <= 1'b1;
            end
            @(posedge clk) go <= 1'b1;
            @(posedge clk) go <= 1'b0;
            repeat (1500) @(posedge clk);
            #1 chk("rx irq", 8'h00, {7'h0, rx_irq});
        end
        rd(2'h0, 8'h20, "not idle");
        rd(2'h2, b1, "data");
        wr(2'h3, 8'h37);
        ev(6, b1);
        ev(6, b1);
        ev(0, 8'h00);
        ev(4, 8'h00);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(2'h0, 8'h00, "reset status one");
        rd(2'h1, 8'h00, "reset status two");
        rd(2'h3, 8'h00, "reset bit rate");
        rd(2'h2, b1, "data kept");
        wr(2'h2, ~b1);
        #1 chk("tx load", 8'h01, {7'h0, tx_load});
        repeat (3) @(posedge clk);
        #1 chk("tx byte", ~b1, tx_byte);
        give_verdict;
    end
endmodule
